// file: bcs_top.sv
// Purpose: bus settings registers, chip-select decode and peripheral access timing
// Assumes: single clock aclk at 200 MHz, synchronous active-low aresetn
// Notes:   reset vector bits are captured on the first cycle after reset; mode straps are only synchronised
`timescale 1ns/1ps
`default_nettype none
module bcs_top #(
   parameter int ADDR_W = 22 // axi byte address width
) (
   // clock and reset
   input  wire  logic              aclk,
   input  wire  logic              aresetn,
   // axi4-lite write address
   input  wire  logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire  logic              s_axi_awvalid,
   output logic                    s_axi_awready,
   // axi4-lite write data
   input  wire  logic [31:0]       s_axi_wdata,
   input  wire  logic [3:0]        s_axi_wstrb,
   input  wire  logic              s_axi_wvalid,
   output logic                    s_axi_wready,
   // axi4-lite write response
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire  logic              s_axi_bready,
   // axi4-lite read address
   input  wire  logic [ADDR_W-1:0] s_axi_araddr,
   input  wire  logic              s_axi_arvalid,
   output logic                    s_axi_arready,
   // axi4-lite read data
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire  logic              s_axi_rready,
   // straps from pins
   input  wire  logic [1:0]        reset_vector_lsbs,
   input  wire  logic              mode_microprocessor,
   input  wire  logic              mode_expansion,
   // cpu access request
   input  wire  logic              cpu_req,
   input  wire  logic              cpu_we,
   input  wire  logic              cpu_periph,
   input  wire  logic [25:0]       cpu_addr,
   output logic                    cpu_ack,
   output logic [31:0]             cpu_addr_full,
   // external bus pins
   output logic [23:0]             ext_addr_q,
   output logic [3:0]              cs_n_q,
   output logic [7:0]              p4_out_q,
   output logic [3:0]              p11_out_q,
   output logic [2:0]              p5_cs_out_q,
   output logic                    ext_mux_active,
   output logic [1:0]              ext_width,
   output logic                    data_pins_gpio,
   output logic                    upper_data_gpio,
   output logic                    addr_valid_q
);
   // strap synchronisers
   logic [1:0] vec_s1_q, vec_s2_q;
   logic [1:0] mode_s1_q, mode_s2_q;
   logic       strap_done_q;
   // registers
   logic [15:0] pbc_q;
   logic [7:4]  route0_q;
   logic [7:0]  prot_q;
   logic [7:0]  bnd01_q, bnd12_q, bnd23_q;
   logic [11:0] spcfg_q;    // per space: [3i+2]=mux, [3i+1:3i]=width
   logic [6:0]  routex_q;   // [3:0] p11 selects, [6:4] p5 selects
   logic        clkctl_q;
   logic        pbc_locked_q;
   // axi state
   logic        aw_held_q, w_held_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   // write decode results, declared ahead of the response logic that reads them
   logic [19:0] widx;
   logic        wr_hit;

   // word index from a byte address
   function automatic logic [19:0] word_idx(input logic [ADDR_W-1:0] a);
      word_idx = a[ADDR_W-1:2];
   endfunction

   // space index of a 26-bit address against the boundaries
   function automatic logic [1:0] space_of(input logic [25:0] a, input logic [7:0] b01,
                                           input logic [7:0] b12, input logic [7:0] b23);
      logic [7:0] up;
      up = a[25:18];
      if (up >= b01)      space_of = 2'h0;
      else if (up >= b12) space_of = 2'h1;
      else if (up >= b23) space_of = 2'h2;
      else                space_of = 2'h3;
   endfunction

   // two-flop straps, then one capture after reset release
   always_ff @(posedge aclk) begin
      vec_s1_q  <= reset_vector_lsbs;
      vec_s2_q  <= vec_s1_q;
      mode_s1_q <= {mode_microprocessor, mode_expansion};
      mode_s2_q <= mode_s1_q;
   end

   wire logic mp_mode  = mode_s2_q[1];
   wire logic exp_mode = mode_s2_q[0];
   wire logic ext_mode = mp_mode | exp_mode;

   // axi write channel capture, either order
   wire logic wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
   assign s_axi_awready = ~aw_held_q;
   assign s_axi_wready  = ~w_held_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q    <= 1'b0;
         w_held_q     <= 1'b0;
         awaddr_q     <= '0;
         wdata_q      <= '0;
         wstrb_q      <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= bcs_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_held_q) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held_q) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? bcs_pkg::RESP_OKAY : bcs_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // write decode
   always_comb begin
      widx   = word_idx(awaddr_q);
      wr_hit = (widx == bcs_pkg::PBC_IDX)   || (widx == bcs_pkg::ROUTE0_IDX) ||
               (widx == bcs_pkg::PROT_IDX)  || (widx == bcs_pkg::BND01_IDX)  ||
               (widx == bcs_pkg::BND12_IDX) || (widx == bcs_pkg::BND23_IDX)  ||
               (widx == bcs_pkg::SPCFG_IDX) || (widx == bcs_pkg::ROUTEX_IDX) ||
               (widx == bcs_pkg::STATUS_IDX)|| (widx == bcs_pkg::CLKCTL_IDX);
   end

   wire logic we_pbc = wr_go && widx == bcs_pkg::PBC_IDX;
   // unlocked write to config: protect must hold the unlock value
   wire logic pbc_ok = we_pbc && prot_q == bcs_pkg::PROT_UNLOCK && !pbc_locked_q;

   // peripheral_bus_config, width from reset vector after reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pbc_q        <= bcs_pkg::PBC_RST;
         strap_done_q <= 1'b0;
      end else begin
         strap_done_q <= 1'b1;
         if (!strap_done_q) begin
            pbc_q[bcs_pkg::WID_LSB +: 2] <= vec_s2_q;
         end else if (pbc_ok) begin
            if (wstrb_q[0]) pbc_q[7:0]  <= {3'h0, wdata_q[4:0]};
            if (wstrb_q[1]) pbc_q[15:8] <= wdata_q[15:8];
         end
      end
   end

   // once the clock control is set, config is frozen; a guard for software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clkctl_q     <= 1'b0;
         pbc_locked_q <= 1'b0;
      end else begin
         if (wr_go && widx == bcs_pkg::CLKCTL_IDX && wstrb_q[0]) clkctl_q <= wdata_q[0];
         if (clkctl_q) pbc_locked_q <= 1'b1;
      end
   end

   // protect, boundaries, routes and per-space config
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prot_q   <= 8'h00;
         route0_q <= 4'h0;
         bnd01_q  <= bcs_pkg::BND01_RST;
         bnd12_q  <= bcs_pkg::BND12_RST;
         bnd23_q  <= bcs_pkg::BND23_RST;
         spcfg_q  <= 12'h000;
         routex_q <= 7'h00;
      end else if (wr_go && wstrb_q[0]) begin
         case (widx)
            bcs_pkg::PROT_IDX:   prot_q   <= wdata_q[7:0];
            bcs_pkg::ROUTE0_IDX: route0_q <= wdata_q[7:4]; // low bits unimplemented
            bcs_pkg::BND01_IDX:  bnd01_q  <= wdata_q[7:0];
            bcs_pkg::BND12_IDX:  bnd12_q  <= wdata_q[7:0];
            bcs_pkg::BND23_IDX:  bnd23_q  <= wdata_q[7:0];
            bcs_pkg::ROUTEX_IDX: routex_q <= wdata_q[6:0];
            bcs_pkg::SPCFG_IDX:  spcfg_q[7:0] <= wdata_q[7:0];
            default: ;
         endcase
         if (widx == bcs_pkg::SPCFG_IDX && wstrb_q[1]) spcfg_q[11:8] <= wdata_q[11:8];
      end else if (wr_go && widx == bcs_pkg::SPCFG_IDX && wstrb_q[1]) begin
         spcfg_q[11:8] <= wdata_q[11:8];
      end
   end

   // axi read: one cycle after address is taken
   logic [31:0] rd_mux;
   logic        rd_hit;
   logic [19:0] ridx;
   always_comb begin
      ridx   = word_idx(s_axi_araddr);
      rd_hit = 1'b1;
      rd_mux = 32'h0;
      case (ridx)
         bcs_pkg::PBC_IDX:    rd_mux = {16'h0, pbc_q};
         bcs_pkg::ROUTE0_IDX: rd_mux = {24'h0, route0_q, 4'h0}; // undefined bits read 0
         bcs_pkg::PROT_IDX:   rd_mux = {24'h0, prot_q};
         bcs_pkg::BND01_IDX:  rd_mux = {24'h0, bnd01_q};
         bcs_pkg::BND12_IDX:  rd_mux = {24'h0, bnd12_q};
         bcs_pkg::BND23_IDX:  rd_mux = {24'h0, bnd23_q};
         bcs_pkg::SPCFG_IDX:  rd_mux = {20'h0, spcfg_q};
         bcs_pkg::ROUTEX_IDX: rd_mux = {25'h0, routex_q};
         bcs_pkg::STATUS_IDX: rd_mux = {26'h0, pbc_locked_q, addr_valid_q, ext_mux_active,
                                        data_pins_gpio, mp_mode, exp_mode};
         bcs_pkg::CLKCTL_IDX: rd_mux = {31'h0, clkctl_q};
         default:             rd_hit = 1'b0;
      endcase
   end

   assign s_axi_arready = ~s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= bcs_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_hit ? bcs_pkg::RESP_OKAY : bcs_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // sign extension of line 25 into the 32-bit map
   assign cpu_addr_full = {{6{cpu_addr[25]}}, cpu_addr};

   // space decode and format, combinational
   logic [1:0] cur_space;
   logic       space_mux;
   always_comb begin
      cur_space = space_of(cpu_addr, bnd01_q, bnd12_q, bnd23_q);
      // global bit forces multiplexed, else per-space bit
      space_mux = pbc_q[bcs_pkg::MUX_BIT] | spcfg_q[3*cur_space+2];
   end
   // global bit wins in every space, select zero space included
   assign ext_mux_active = space_mux;
   // width field; the illegal code is treated as 32 bits
   assign ext_width = (pbc_q[bcs_pkg::WID_LSB +: 2] == bcs_pkg::W8) ? bcs_pkg::W8 :
                      (pbc_q[bcs_pkg::WID_LSB +: 2] == bcs_pkg::W16) ? bcs_pkg::W16 :
                      bcs_pkg::W32;
   // global bit and all four per-space mux bits set frees the data ports
   assign data_pins_gpio = pbc_q[bcs_pkg::MUX_BIT] & spcfg_q[2] & spcfg_q[5] &
                           spcfg_q[8] & spcfg_q[11];
   assign upper_data_gpio = (ext_width != bcs_pkg::W32);

   // peripheral access stalls for the programmed count
   logic [4:0] wait_q;
   logic       busy_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wait_q <= 5'h0;
         busy_q <= 1'b0;
      end else if (!busy_q && cpu_req && cpu_periph) begin
         busy_q <= 1'b1;
         wait_q <= cpu_we ? pbc_q[bcs_pkg::WR_LSB +: 5] : pbc_q[bcs_pkg::RD_LSB +: 5];
      end else if (busy_q) begin
         if (wait_q == 5'h0) busy_q <= 1'b0;
         else wait_q <= wait_q - 5'h1;
      end
   end
   // external accesses answer at once; peripheral ones after the count
   assign cpu_ack = cpu_req & (~cpu_periph | (busy_q & wait_q == 5'h0));

   // external address and chip selects, held between accesses
   wire logic ext_acc = cpu_req & ~cpu_periph & ext_mode;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_addr_q   <= 24'h0;
         cs_n_q       <= 4'hf;
         addr_valid_q <= 1'b0;
      end else if (ext_acc) begin
         ext_addr_q   <= cpu_addr[23:0];
         cs_n_q       <= ~(4'h1 << cur_space);
         addr_valid_q <= 1'b1;
      end else if (!ext_mode) begin
         addr_valid_q <= 1'b0; // undefined again until next access
      end
   end

   // pin muxing of selects onto shared and alternate pins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p4_out_q    <= 8'h0;
         p11_out_q   <= 4'hf;
         p5_cs_out_q <= 3'h7;
      end else begin
         p4_out_q[3:0] <= ext_addr_q[19:16];
         p4_out_q[4] <= route0_q[bcs_pkg::P44_BIT] ? cs_n_q[3] : ext_addr_q[20];
         p4_out_q[5] <= route0_q[bcs_pkg::P45_BIT] ? cs_n_q[2] : ext_addr_q[21];
         p4_out_q[6] <= route0_q[bcs_pkg::P46_BIT] ? cs_n_q[1] : ext_addr_q[22];
         // select zero on its shared pin after reset in microprocessor mode
         p4_out_q[7] <= (route0_q[bcs_pkg::P47_BIT] | mp_mode) ? cs_n_q[0] : ext_addr_q[23];
         p11_out_q   <= cs_n_q | ~routex_q[3:0];
         p5_cs_out_q <= cs_n_q[3:1] | ~routex_q[6:4];
      end
   end
endmodule // bcs_top
`default_nettype wire

// file: bcs_pkg.sv
// Purpose: constants for the bus configuration and chip-select block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   register offsets are word indexes; byte address is four times the index
package bcs_pkg;
   // register indexes (printed offsets are not all word multiples)
   localparam logic [19:0] PBC_IDX      = 20'h0001e; // peripheral_bus_config
   localparam logic [19:0] ROUTE0_IDX   = 20'h40054; // chip_select_pin_route_0
   localparam logic [19:0] PROT_IDX     = 20'h00100; // write_protect_reg
   localparam logic [19:0] BND01_IDX    = 20'h00101; // boundary_space0_1
   localparam logic [19:0] BND12_IDX    = 20'h00102; // boundary_space1_2
   localparam logic [19:0] BND23_IDX    = 20'h00103; // boundary_space2_3
   localparam logic [19:0] SPCFG_IDX    = 20'h00104; // per-space format/width
   localparam logic [19:0] ROUTEX_IDX   = 20'h00105; // extra chip-select routes
   localparam logic [19:0] STATUS_IDX   = 20'h00106; // block status
   localparam logic [19:0] CLKCTL_IDX   = 20'h00107; // clock_control_reg
   // reset values and protect unlock key
   localparam logic [15:0] PBC_RST      = 16'h0504;
   localparam logic [7:0]  PROT_UNLOCK  = 8'haa;
   localparam logic [7:0]  BND01_RST    = 8'hff;
   localparam logic [7:0]  BND12_RST    = 8'hff;
   localparam logic [7:0]  BND23_RST    = 8'hff;
   // peripheral_bus_config fields
   localparam int RD_LSB   = 0;
   localparam int WR_LSB   = 8;
   localparam int MUX_BIT  = 13;
   localparam int WID_LSB  = 14;
   // chip_select_pin_route_0 fields
   localparam int P44_BIT  = 4;
   localparam int P45_BIT  = 5;
   localparam int P46_BIT  = 6;
   localparam int P47_BIT  = 7;
   // width encodings
   localparam logic [1:0] W8  = 2'h0;
   localparam logic [1:0] W16 = 2'h1;
   localparam logic [1:0] W32 = 2'h2;
   // address geometry
   localparam int INT_ADDR_W = 26;
   localparam int EXT_ADDR_W = 24;
   localparam int BND_SHIFT  = 18;
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: bcs_props.sv
// Purpose: port-level assertions for the bus config and chip-select block
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound into bcs_top, watches only its ports
`timescale 1ns/1ps
`default_nettype none
module bcs_props (
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // register bus handshakes
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // cpu side
   input wire logic        cpu_req,
   input wire logic        cpu_periph,
   input wire logic [25:0] cpu_addr,
   input wire logic        cpu_ack,
   input wire logic [31:0] cpu_addr_full,
   // external pins and status
   input wire logic [23:0] ext_addr_q,
   input wire logic [3:0]  cs_n_q,
   input wire logic [3:0]  p11_out_q,
   input wire logic [1:0]  ext_width,
   input wire logic        ext_mux_active,
   input wire logic        data_pins_gpio
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // low address one cycle back, so the pin check sees its cause
   logic [23:0] addr_lo_q;
   always_ff @(posedge aclk) begin
      addr_lo_q <= cpu_addr[23:0];
   end
   AST_RST_IDLE: assert property ($rose(aresetn) |-> cs_n_q == 4'hf && p11_out_q == 4'hf)
      else $error("selects not idle after reset");
   AST_ONE_SEL: assert property ($countones(~cs_n_q) <= 1)
      else $error("more than one select low");
   AST_SIGN_EXT: assert property (cpu_addr_full == {{6{cpu_addr[25]}}, cpu_addr})
      else $error("address not sign extended");
   AST_EXT_ACK: assert property (cpu_req && !cpu_periph |-> cpu_ack)
      else $error("external access not acknowledged at once");
   AST_EXT_ADDR: assert property (cpu_req && !cpu_periph |=>
      ext_addr_q == addr_lo_q && cs_n_q != 4'hf)
      else $error("external address or select missing");
   AST_PER_WAIT: assert property ($rose(cpu_req) && cpu_periph |->
      !cpu_ack ##[1:40] cpu_ack)
      else $error("peripheral wait wrong");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   // both taken at one edge: the pair is held one cycle, then the response rises
   AST_W_ANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
      else $error("write response late");
   AST_GPIO_MUX: assert property (data_pins_gpio |-> ext_mux_active)
      else $error("data pins freed without multiplexed format");
   AST_WIDTH_OK: assert property (ext_width != 2'h3)
      else $error("illegal width code on output");
   // main scenarios reached
   cover property (cpu_req && cpu_periph && cpu_ack);
   cover property (data_pins_gpio);
   cover property (s_axi_bvalid && s_axi_bresp == bcs_pkg::RESP_SLVERR);
endmodule // bcs_props
bind bcs_top bcs_props bcs_props_inst (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .cpu_req(cpu_req), .cpu_periph(cpu_periph), .cpu_addr(cpu_addr),
   .cpu_ack(cpu_ack), .cpu_addr_full(cpu_addr_full), .ext_addr_q(ext_addr_q), .cs_n_q(cs_n_q),
   .p11_out_q(p11_out_q), .ext_width(ext_width), .ext_mux_active(ext_mux_active),
   .data_pins_gpio(data_pins_gpio));
`default_nettype wire

// file: bcs_ext_dev.sv
// Purpose: passive model of the memory chips on the external bus
// Assumes: selects active low, sampled on the bus clock
// Notes:   drives nothing back; records which spaces were selected
`timescale 1ns/1ps
`default_nettype none
module bcs_ext_dev (
   // clock and clear
   input  wire logic        aclk,
   input  wire logic        clr,
   // pins from the block
   input  wire logic [3:0]  cs_n_q,
   input  wire logic [23:0] ext_addr_q,
   // record
   output logic [3:0]       seen_q,
   output logic [23:0]      last_addr_q
);
   // the address is latched whenever any select is low
   always_ff @(posedge aclk) begin
      if (clr) begin
         seen_q <= 4'h0;
      end else begin
         seen_q <= seen_q | ~cs_n_q;
      end
      if (cs_n_q != 4'hf) begin
         last_addr_q <= ext_addr_q;
      end
   end
endmodule // bcs_ext_dev
`default_nettype wire

// file: tb_bcs_top.sv
// Purpose: self-checking bench for the bus config and chip-select block
// Assumes: reset vector low bits 01, microprocessor mode strap set
// Notes:   register and external bus results are queued by the drivers and compared by monitors; waits and pins are checked inline
`timescale 1ns/1ps
`default_nettype none
module tb_bcs_top;
   // design signals
   logic        aclk, aresetn, cpu_req, cpu_we, cpu_periph, cpu_ack;
   logic [21:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, cpu_addr_full;
   logic [3:0]  s_axi_wstrb, cs_n_q, p11_out_q, seen;
   logic [1:0]  s_axi_bresp, s_axi_rresp, ext_width;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        ext_mux_active, data_pins_gpio, ext_pend, upper_gpio, addr_valid;
   logic [7:0]  p4;
   logic [2:0]  p5;
   logic [25:0] cpu_addr;
   logic [23:0] ext_addr_q;
   // bench state and tables
   int          error_cnt, checked, seed;
   logic [1:0]  wq[$];
   logic [33:0] rq[$];
   logic [27:0] cq[$];
   logic [27:0] ce;
   logic [33:0] re;
   logic [4:0]  tr [3] = '{5'h04, 5'h0d, 5'h0f};
   logic [4:0]  tw [3] = '{5'h05, 5'h0a, 5'h0f};
   logic [7:0]  ups [4] = '{8'hc0, 8'h9a, 8'h40, 8'h3f};
   bcs_top bcs_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .reset_vector_lsbs(2'h1), .mode_microprocessor(1'h1),
      .mode_expansion(1'h0), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_periph(cpu_periph),
      .cpu_addr(cpu_addr), .cpu_ack(cpu_ack), .cpu_addr_full(cpu_addr_full),
      .ext_addr_q(ext_addr_q), .cs_n_q(cs_n_q), .p4_out_q(p4), .p11_out_q(p11_out_q),
      .p5_cs_out_q(p5), .ext_mux_active(ext_mux_active), .ext_width(ext_width),
      .data_pins_gpio(data_pins_gpio), .upper_data_gpio(upper_gpio), .addr_valid_q(addr_valid));
   bcs_ext_dev bcs_ext_dev_inst (.aclk(aclk), .clr(!aresetn), .cs_n_q(cs_n_q),
      .ext_addr_q(ext_addr_q), .seen_q(seen), .last_addr_q());
   // 200 MHz clock
   initial begin
      aclk = 1'h0;
      forever #2.5 aclk = ~aclk;
   end
   // one comparison, counted
   task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v, input string nm);
      checked++;
      if (seen_v !== exp_v) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp_v, seen_v);
      end
   endtask
   // register write: address and data offered together, held until taken
   task automatic axw(input logic [19:0] idx, input logic [31:0] d, input logic [1:0] er);
      logic aw_ok, w_ok;
      wq.push_back(er);
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      {aw_ok, w_ok} = 2'h0;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok = 1'h1;
            s_axi_awvalid <= 1'h0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok = 1'h1;
            s_axi_wvalid <= 1'h0;
         end
      end
      while (!s_axi_bvalid) @(posedge aclk);
      s_axi_bready <= 1'h0;
      @(posedge aclk);
   endtask
   // register read; expected word and response go on the queue
   task automatic axr(input logic [19:0] idx, input logic [31:0] d, input logic [1:0] er);
      rq.push_back({er, d});
      s_axi_araddr <= {idx, 2'h0};
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      while (!s_axi_rvalid) @(posedge aclk);
      s_axi_rready <= 1'h0;
      @(posedge aclk);
   endtask
   // peripheral access; wait must follow the programmed timing count
   task automatic cpu_per(input logic we, input int f);
      int n;
      cpu_addr <= 26'($random(seed));
      {cpu_req, cpu_we, cpu_periph} <= {1'h1, we, 1'h1};
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (!cpu_ack && n < 100);
      cpu_req <= 1'h0;
      chk(n >= f + 1 && n <= f + 3, 1'h1, "periph wait");
      @(posedge aclk);
   endtask
   // monitors take the oldest note whenever a result shows
   always @(posedge aclk) begin
      if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp, wq.pop_front(), "bresp");
      if (s_axi_rvalid && s_axi_rready) begin
         re = rq.pop_front();
         chk(s_axi_rdata, re[31:0], "rdata");
         chk(s_axi_rresp, re[33:32], "rresp");
      end
      if (ext_pend) begin
         ce = cq.pop_front();
         chk(cs_n_q, ce[27:24], "select");
         chk(ext_addr_q, ce[23:0], "ext addr");
      end
      ext_pend = aresetn && cpu_req && !cpu_periph && cpu_ack;
   end
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge aclk);
      error_cnt++;
      wrap_up();
   end
   // main sequence
   initial begin
      int i;
      logic [31:0] r;
      logic [25:0] a;
      {error_cnt, checked, seed} = {32'h0, 32'h0, 32'd99554};
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h0;
      {s_axi_rready, cpu_req, cpu_we, cpu_periph, ext_pend} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cpu_addr} = '0;
      s_axi_wstrb = 4'hf;
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (2) @(posedge aclk);
      axr(bcs_pkg::PBC_IDX, 32'h4504, 2'h0);
      axw(bcs_pkg::PBC_IDX, 32'h8a0d, 2'h0);
      axr(bcs_pkg::PBC_IDX, 32'h4504, 2'h0);
      axw(bcs_pkg::PROT_IDX, {24'h0, bcs_pkg::PROT_UNLOCK}, 2'h0);
      for (i = 0; i < 3; i++) begin
         axw(bcs_pkg::PBC_IDX, {16'h0, 3'h2, tw[i], 3'h0, tr[i]}, 2'h0);
         cpu_per(1'h0, tr[i]);
         cpu_per(1'h1, tw[i]);
      end
      axr(bcs_pkg::PBC_IDX, 32'h4f0f, 2'h0);
      chk(ext_width, bcs_pkg::W16, "width");
      axw(bcs_pkg::SPCFG_IDX, 32'h924, 2'h0);
      axw(bcs_pkg::PBC_IDX, 32'h6f0f, 2'h0);
      chk(ext_mux_active, 1'h1, "mux");
      chk(data_pins_gpio, 1'h1, "gpio");
      axw(bcs_pkg::CLKCTL_IDX, 32'h1, 2'h0);
      axw(bcs_pkg::PBC_IDX, 32'h0, 2'h0);
      axr(bcs_pkg::PBC_IDX, 32'h6f0f, 2'h0);
      r = $random(seed);
      axw(bcs_pkg::ROUTE0_IDX, r, 2'h0);
      axr(bcs_pkg::ROUTE0_IDX, {24'h0, r[7:4], 4'h0}, 2'h0);
      axw(20'h00200, r, bcs_pkg::RESP_SLVERR);
      axr(20'h00200, 32'h0, bcs_pkg::RESP_SLVERR);
      for (i = 0; i < 3; i++) axr(bcs_pkg::BND01_IDX + 20'(i), 32'hff, 2'h0);
      axw(bcs_pkg::BND01_IDX, 32'hc0, 2'h0);
      axw(bcs_pkg::BND12_IDX, 32'h80, 2'h0);
      axw(bcs_pkg::BND23_IDX, 32'h40, 2'h0);
      // back-to-back external accesses across all four spaces
      for (i = 0; i < 8; i++) begin
         a = {ups[i % 4], 18'($random(seed))};
         cpu_addr <= a;
         {cpu_req, cpu_we, cpu_periph} <= 3'h4;
         cq.push_back({~(4'h1 << (i % 4)), a[23:0]});
         @(posedge aclk);
         chk(cpu_ack, 1'h1, "ext ack");
         // pin 47 lags the access by two edges; space 0 pulls it low
         if (i > 1) chk(p4[7], (i % 4) != 2, "pin47 select zero");
      end
      cpu_req <= 1'h0;
      repeat (2) @(posedge aclk);
      chk(seen, 4'hf, "spaces");
      chk(p11_out_q, 4'hf, "unrouted pins");
      chk(p5, 3'h7, "unrouted alt pins");
      chk(p4[4], !r[4], "pin44 address or select");
      chk(addr_valid, 1'h1, "address valid");
      chk(upper_gpio, 1'h1, "upper data pins free");
      wrap_up();
   end
endmodule // tb_bcs_top
`default_nettype wire
